// *** shared/wiper_pkg.sv ***
/*
 * Shared constants and types for the serial wiper latch control block.
 * Assumes a single core clock; all serial pins are asynchronous to it.
 */
package wiper_pkg;
	localparam int          CODE_W       = 8;
	localparam int          CHANNELS     = 2;
	localparam int          SHIFT_W      = 9;
	localparam int          ONE_WORD_LEN = 8;
	localparam int          TWO_WORD_LEN = 9;
	localparam logic [7:0]  MIDSCALE     = 8'h80;
	localparam int          SEL_POS      = 8;
	localparam int          SYNC_STAGES  = 3;

	// Pin group sampled from the serial port.
	typedef struct packed {
		logic serialClk;
		logic chipSelN;
		logic serialDataIn;
	} serial_pins_t;

	// Per-channel analog switch controls.
	typedef struct packed {
		logic [7:0] code;
		logic       terminalAOpen;
		logic       wiperToB;
	} wiper_ctrl_t;
endpackage

// *** verification/host_model.sv ***
/* Host that drives the serial port of the wiper block.
   Assumes the bench owns the core clock and reset. */
`timescale 1ns/1ps
module host_model (
	input  wire logic               core_clk,
	output wiper_pkg::serial_pins_t pins
);
	import wiper_pkg::*;
	// Idle with chip select high and the serial clock low.
	initial pins = 3'b010;
	// Each level lasts at least five core cycles so the pin filters see it.
	task automatic sendWord(input logic [11:0] w, input int n);
		@(negedge core_clk) pins.chipSelN = 1'b0;
		repeat (5) @(negedge core_clk);
		for (int i = n - 1; i >= 0; i--) begin
			pins.serialDataIn = w[i];
			repeat (5) @(negedge core_clk);
			pins.serialClk = 1'b1;
			repeat (5) @(negedge core_clk);
			pins.serialClk = 1'b0;
		end
		repeat (5) @(negedge core_clk);
		pins.chipSelN = 1'b1;
		// A released data line must not keep its old value.
		pins.serialDataIn = ~pins.serialDataIn;
		repeat (10) @(negedge core_clk);
	endtask
endmodule

// *** verification/serial_wiper_latch_control_test.sv ***
/* Self-checking bench for the wiper block.
   Assumes the host model drives all serial pins. */
`timescale 1ns/1ps
module serial_wiper_latch_control_test;
	import wiper_pkg::*;
	logic         core_clk = 1'b0;
	logic         rst      = 1'b1;
	logic         forceN   = 1'b1;
	logic         downN    = 1'b1;
	logic         sdoO;
	logic         sdoOe;
	serial_pins_t pins;
	wiper_ctrl_t  one;
	wiper_ctrl_t  two;
	int           fails    = 0;
	int           checked  = 0;
	int           cycles   = 0;
	// Half of the 50 ns period.
	always #25 core_clk = ~core_clk;
	host_model host (.core_clk(core_clk), .pins(pins));
	serial_wiper_latch_control #(.DUAL(1'b1)) DUT (.core_clk(core_clk), .rst(rst),
		.pins(pins), .midscale_force_n(forceN), .power_down_n(downN),
		.serial_data_out_o(sdoO), .serial_data_out_oe(sdoOe),
		.channel_one_ctrl(one), .channel_two_ctrl(two));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic testPowerOn();
		chk(one.code, 8'h80);
		chk(two.code, 8'h80);
		chk({7'h00, sdoO}, 8'h00);
		chk({7'h00, sdoOe}, 8'h00);
	endtask
	task automatic testSelect();
		host.sendWord(12'h03c, 9);
		chk(one.code, 8'h3c);
		chk(two.code, 8'h80);
		host.sendWord(12'h1a5, 9);
		chk(two.code, 8'ha5);
		chk(one.code, 8'h3c);
	endtask
	task automatic testOverlength();
		host.sendWord(12'hf5a, 12);
		chk(two.code, 8'h5a);
		chk(one.code, 8'h3c);
	endtask
	task automatic testShutdown();
		@(negedge core_clk) downN = 1'b0;
		repeat (2) @(negedge core_clk);
		chk({6'h00, two.terminalAOpen, two.wiperToB}, 8'h03);
		chk(two.code, 8'h5a);
		chk({7'h00, sdoOe}, 8'h00);
		downN = 1'b1;
		repeat (2) @(negedge core_clk);
		chk({6'h00, one.terminalAOpen, one.wiperToB}, 8'h00);
		chk(one.code, 8'h3c);
	endtask
	task automatic testPreset();
		@(negedge core_clk) forceN = 1'b0;
		repeat (2) @(negedge core_clk);
		chk(one.code, 8'h80);
		chk(two.code, 8'h80);
		forceN = 1'b1;
		repeat (2) @(negedge core_clk);
	endtask
	task automatic give_verdict();
		$display("Compared %0d values, %0d mismatches", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// A hang is cut short well past the expected run length.
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			give_verdict();
		end
	end
	// Reset is held for twenty cycles, then the filters settle.
	initial begin
		repeat (20) @(negedge core_clk);
		rst = 1'b0;
		repeat (6) @(negedge core_clk);
		testPowerOn();
		testSelect();
		testOverlength();
		testShutdown();
		testPreset();
		give_verdict();
	end
endmodule

// *** verilog/pin_sync.sv ***
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes the pin is asynchronous to core_clk.
 */
`timescale 1ns/1ps
module pin_sync (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic pinIn,
	input  wire logic resetLevel,
	output logic      pinOut
);
	import wiper_pkg::*;
	logic [SYNC_STAGES-1:0] stage_q;

	// Stage 0 feeds only stage 1; the output moves once stages 1 and 2 agree.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stage_q <= '0;
			pinOut  <= 1'b0;
		end else begin
			stage_q <= {stage_q[1:0], pinIn};
			if (stage_q[1] == stage_q[2])
				pinOut <= stage_q[2];
		end
	end

	wire unusedLevel = resetLevel;
endmodule

// *** verilog/serial_wiper_latch_control.sv ***
/*
 * Serial wiper latch control: shift register, chip-select load, preset and shutdown.
 * Assumes pins arrive asynchronously and are sampled on core_clk at 20 MHz,
 * so the serial clock must be far slower than the core clock.
 */
`timescale 1ns/1ps
module serial_wiper_latch_control #(
	parameter bit DUAL = 1'b1
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire wiper_pkg::serial_pins_t pins,
	input  wire logic                 midscale_force_n,
	input  wire logic                 power_down_n,
	output logic                      serial_data_out_o,
	output logic                      serial_data_out_oe,
	output wiper_pkg::wiper_ctrl_t    channel_one_ctrl,
	output wiper_pkg::wiper_ctrl_t    channel_two_ctrl
);
	import wiper_pkg::*;

	logic              clkS;
	logic              csNS;
	logic              csSel;
	logic              sdiS;
	logic              clkPrev_q;
	logic              csPrev_q;
	logic [SHIFT_W-1:0] shift_q;
	logic [CODE_W-1:0] channel_one_latch;
	logic [CODE_W-1:0] channel_two_latch;
	logic              outLatch_q;
	logic              presetN_a;

	// Serial pins pass the three-stage filter; preset is used asynchronously.
	pin_sync uClk (.core_clk(core_clk), .rst(rst), .pinIn(pins.serialClk),
		.resetLevel(1'b0), .pinOut(clkS));
	// Chip select is inverted before its filter, so the filter's cleared state means deselected.
	// Otherwise the filter would leave reset showing select, and the climb to the idle
	// high level would look like a closing frame and load zero into channel one.
	pin_sync uCs (.core_clk(core_clk), .rst(rst), .pinIn(~pins.chipSelN),
		.resetLevel(1'b0), .pinOut(csSel));
	assign csNS = ~csSel;
	pin_sync uSdi (.core_clk(core_clk), .rst(rst), .pinIn(pins.serialDataIn),
		.resetLevel(1'b0), .pinOut(sdiS));

	// Edge decode of filtered pins.
	wire clkRise   = clkS & ~clkPrev_q;
	wire shiftEn   = clkRise & ~csNS;
	wire csRise    = csNS & ~csPrev_q;
	wire selBit    = DUAL ? shift_q[SEL_POS] : 1'b0;
	wire loadOne   = csRise & ~selBit;
	wire loadTwo   = csRise & selBit & DUAL;
	wire presetAct = rst | ~midscale_force_n;

	// Edge history; chip select idles high so no false load at release.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			clkPrev_q <= 1'b0;
			csPrev_q  <= 1'b1;
		end else begin
			clkPrev_q <= clkS;
			csPrev_q  <= csNS;
		end
	end

	// Shift register keeps the most recent bits only; older ones fall off.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			shift_q <= '0;
		else if (shiftEn)
			shift_q <= {shift_q[SHIFT_W-2:0], sdiS};
	end

	// Output latch holds the bit entered eight edges earlier, cleared by preset.
	always_ff @(posedge core_clk or posedge presetAct) begin
		if (presetAct)
			outLatch_q <= 1'b0;
		else if (shiftEn)
			outLatch_q <= shift_q[ONE_WORD_LEN-1];
	end

	// Wiper latches: preset is asynchronous and so wins over any load.
	always_ff @(posedge core_clk or posedge presetAct) begin
		if (presetAct) begin
			channel_one_latch <= MIDSCALE;
			channel_two_latch <= MIDSCALE;
		end else begin
			if (loadOne)
				channel_one_latch <= shift_q[CODE_W-1:0];
			if (loadTwo)
				channel_two_latch <= shift_q[CODE_W-1:0];
		end
	end

	// Shutdown changes only the switch controls and the data-out enable, never the latches.
	assign channel_one_ctrl = '{code: channel_one_latch,
		terminalAOpen: ~power_down_n, wiperToB: ~power_down_n};
	assign channel_two_ctrl = '{code: channel_two_latch,
		terminalAOpen: ~power_down_n, wiperToB: ~power_down_n};

	// Open drain: drive low only, and switch off during shutdown or deselect.
	assign serial_data_out_o  = 1'b0;
	assign serial_data_out_oe = ~outLatch_q & ~csNS & power_down_n;

	a_shift_idle: assert property (@(posedge core_clk) disable iff (rst)
		csNS |=> $stable(shift_q)) else $error("shift moved while deselected");
	a_load_one: assert property (@(posedge core_clk) disable iff (rst)
		(loadOne && midscale_force_n) |=> channel_one_latch == $past(shift_q[7:0]))
		else $error("channel one not loaded");
	a_load_two: assert property (@(posedge core_clk) disable iff (rst)
		(loadTwo && midscale_force_n) |=> channel_two_latch == $past(shift_q[7:0]))
		else $error("channel two not loaded");
	a_other_kept: assert property (@(posedge core_clk) disable iff (rst)
		(loadOne && midscale_force_n) |=> $stable(channel_two_latch))
		else $error("wrong channel loaded");
	a_preset_mid: assert property (@(posedge core_clk) disable iff (rst)
		!midscale_force_n |-> channel_one_latch == MIDSCALE && channel_two_latch == MIDSCALE)
		else $error("preset not at midscale");
	a_preset_out: assert property (@(posedge core_clk) disable iff (rst)
		!midscale_force_n |-> !outLatch_q) else $error("output latch not cleared");
	a_shut_keep: assert property (@(posedge core_clk) disable iff (rst)
		(!power_down_n && csNS && midscale_force_n) |=> $stable(channel_one_latch))
		else $error("latch lost in shutdown");
	a_shut_sw: assert property (@(posedge core_clk) disable iff (rst)
		!power_down_n |-> channel_one_ctrl.terminalAOpen && !serial_data_out_oe)
		else $error("shutdown switches wrong");
	a_delay_out: assert property (@(posedge core_clk) disable iff (rst || !midscale_force_n)
		shiftEn |=> outLatch_q == $past(shift_q[7])) else $error("output bit wrong");
	a_od_low: assert property (@(posedge core_clk) disable iff (rst)
		serial_data_out_o == 1'b0) else $error("output drives high");

	// A load that meets an active preset must leave both latches centred.
	// Loads are one frame apart, so the cycle after cannot hold a second load.
	a_preset_wins: assert property (@(posedge core_clk) disable iff (rst)
		(csRise && !midscale_force_n) |=>
		channel_one_latch == MIDSCALE && channel_two_latch == MIDSCALE)
		else $error("load beat the preset");

	// A load to channel two must not disturb channel one.
	a_two_only: assert property (@(posedge core_clk) disable iff (rst)
		(loadTwo && midscale_force_n) |=> $stable(channel_one_latch))
		else $error("channel one hit by channel two load");

	// Channel two is picked only by a set select bit.
	a_sel_decode: assert property (@(posedge core_clk) disable iff (rst)
		loadTwo |-> shift_q[SEL_POS])
		else $error("channel two picked without select");

	// With chip select high the open-drain transistor stays off.
	a_oe_desel: assert property (@(posedge core_clk) disable iff (rst)
		csNS |-> !serial_data_out_oe)
		else $error("output driven while deselected");

	// The output latch only moves on a shifting edge or a preset.
	a_out_hold: assert property (@(posedge core_clk) disable iff (rst || !midscale_force_n)
		!shiftEn |=> $stable(outLatch_q))
		else $error("output latch moved without a shift");

	// Covers for the main scenarios: each load, a preset meeting a load, and shutdown.
	c_load_one: cover property (@(posedge core_clk) disable iff (rst) loadOne);
	c_load_two: cover property (@(posedge core_clk) disable iff (rst) loadTwo);
	c_preset_load: cover property (@(posedge core_clk) disable iff (rst)
		csRise && !midscale_force_n);
	c_shutdown: cover property (@(posedge core_clk) disable iff (rst) !power_down_n);
endmodule
